// >>> hdl/dual_pin_gpio.sv
// Two general pins with direction, output level and pulse-width input decoding over APB
// What this block does
// - Bit 9 makes pin one an output when 1 and an input when 0, resetting to 0.
// - Bit 8 makes pin zero an output when 1 and an input when 0, resetting to 0.
// - Bits 7:6 pick pin one's decode time base of 16, 64, 256 or 1024 clocks, resetting to 00.
// - Bits 5:4 pick pin zero's decode time base of 16, 64, 256 or 1024 clocks, resetting to 00.
// - Bits 3:2 are spare read/write storage resetting to 00 that steers nothing.
// - Bit 1 is the level driven on pin one while it is an output, ignored as input.
// - Bit 0 is the level driven on pin zero while it is an output, ignored as input.
// - A format bit per pin reads an input as a static level or as a decoded pulse width.
// - Neither pin drives a pulse-width output; outputs only drive the static level bit.
module dual_pin_gpio
    import pin_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic general_pin_zero_in,
    output logic general_pin_zero_out,
    output logic general_pin_zero_oe,
    input wire logic general_pin_one_in,
    output logic general_pin_one_out,
    output logic general_pin_one_oe
);
    logic [15:0] cfg;
    logic [15:0] next_cfg;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic slverr;
    logic next_slverr;
    logic [15:0] lane_mask;
    logic access;
    logic hit_cfg;
    logic hit_level;
    logic setup;
    logic refuse;
    logic cfg_write;
    logic [31:0] status_word;
    pin_ctrl_t ctrl_zero;
    pin_ctrl_t ctrl_one;
    pin_meas_t meas_zero;
    pin_meas_t meas_one;
    logic out_zero;
    logic out_one;
    logic oe_zero;
    logic oe_one;
    logic next_out_zero;
    logic next_out_one;
    logic next_oe_zero;
    logic next_oe_one;

    // =========================================
    // Per-pin control fields
    always_comb
    begin
        ctrl_zero.format = cfg[pin_zero_format_bit];
        ctrl_zero.direction = cfg[pin_zero_direction_bit];
        ctrl_zero.timebase = cfg[pin_zero_timebase_lsb +: 2];
        ctrl_zero.output_level = cfg[pin_zero_output_bit];
        ctrl_one.format = cfg[pin_one_format_bit];
        ctrl_one.direction = cfg[pin_one_direction_bit];
        ctrl_one.timebase = cfg[pin_one_timebase_lsb +: 2];
        ctrl_one.output_level = cfg[pin_one_output_bit];
    end

    // =========================================
    // APB decode, zero wait states
    // Setup cycle captures the answer; access cycle applies the write
    always_comb
    begin
        setup = psel && !penable;
        access = psel && penable;
        hit_cfg = (paddr == cfg_offset);
        hit_level = (paddr == level_offset);
        refuse = !(hit_cfg || hit_level) || (pwrite && hit_level);
        cfg_write = access && pwrite && hit_cfg;
        lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & cfg_write_mask;
    end

    // =========================================
    // Configuration register
    always_comb
    begin
        next_cfg = cfg;
        if (cfg_write)
        begin
            next_cfg = (cfg & ~lane_mask) | (pwdata[15:0] & lane_mask);
        end
        // Top bit is read-only and always reads one
        next_cfg[reserved_one_bit] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg <= cfg_reset;
        end
        else
        begin
            cfg <= next_cfg;
        end
    end

    // =========================================
    // Read data and refusal, captured in the setup cycle
    always_comb
    begin
        status_word = {30'h0000_0000, meas_one.level, meas_zero.level};
        next_rdata = rdata;
        next_slverr = 1'b0;
        if (setup)
        begin
            next_slverr = refuse;
            next_rdata = 32'h0000_0000;
            if (!pwrite && hit_cfg)
            begin
                next_rdata = {16'h0000, cfg};
            end
            else if (!pwrite && hit_level)
            begin
                next_rdata = status_word;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata <= 32'h0000_0000;
            slverr <= 1'b0;
        end
        else
        begin
            rdata <= next_rdata;
            slverr <= next_slverr;
        end
    end

    assign pready = 1'b1;
    assign prdata = rdata;
    assign pslverr = access ? slverr : 1'b0;

    // =========================================
    // Pin zero driver, static level only
    // An input pin is never driven, whatever its level bit holds
    always_comb
    begin
        next_oe_zero = ctrl_zero.direction;
        next_out_zero = ctrl_zero.direction && ctrl_zero.output_level;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_zero <= 1'b0;
            oe_zero <= 1'b0;
        end
        else
        begin
            out_zero <= next_out_zero;
            oe_zero <= next_oe_zero;
        end
    end

    assign general_pin_zero_out = out_zero;
    assign general_pin_zero_oe = oe_zero;

    // =========================================
    // Pin one driver, static level only
    always_comb
    begin
        next_oe_one = ctrl_one.direction;
        next_out_one = ctrl_one.direction && ctrl_one.output_level;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_one <= 1'b0;
            oe_one <= 1'b0;
        end
        else
        begin
            out_one <= next_out_one;
            oe_one <= next_oe_one;
        end
    end

    assign general_pin_one_out = out_one;
    assign general_pin_one_oe = oe_one;

    // =========================================
    // Input decoders
    pin_input_decoder u_dec_zero (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(general_pin_zero_in),
        .ctrl(ctrl_zero),
        .meas(meas_zero)
    );

    pin_input_decoder u_dec_one (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(general_pin_one_in),
        .ctrl(ctrl_one),
        .meas(meas_one)
    );
endmodule

// >>> hdl/pin_cfg_pkg.sv
// Package with register layout, reset values and timing constants of the pin block
package pin_cfg_pkg;
    localparam logic [11:0] cfg_offset = 12'h000;
    localparam logic [11:0] level_offset = 12'h004;
    localparam int pin_one_direction_bit = 9;
    localparam int pin_zero_direction_bit = 8;
    localparam int pin_one_format_bit = 11;
    localparam int pin_zero_format_bit = 10;
    localparam int pin_one_timebase_lsb = 6;
    localparam int pin_zero_timebase_lsb = 4;
    localparam int spare_low_lsb = 2;
    localparam int spare_high_lsb = 12;
    localparam int reserved_one_bit = 15;
    localparam int pin_one_output_bit = 1;
    localparam int pin_zero_output_bit = 0;
    localparam logic [15:0] cfg_reset = 16'h8000;
    localparam logic [15:0] cfg_write_mask = 16'h7fff;
    localparam logic [1:0] tb_code_16 = 2'h0;
    localparam logic [1:0] tb_code_64 = 2'h1;
    localparam logic [1:0] tb_code_256 = 2'h2;
    localparam logic [1:0] tb_code_1024 = 2'h3;
    localparam logic [10:0] tb_periods_16 = 11'h010;
    localparam logic [10:0] tb_periods_64 = 11'h040;
    localparam logic [10:0] tb_periods_256 = 11'h100;
    localparam logic [10:0] tb_periods_1024 = 11'h400;
    localparam logic [10:0] tb_one = 11'h001;
    localparam int width_bits = 16;

    typedef struct packed {
        logic format;
        logic direction;
        logic [1:0] timebase;
        logic output_level;
    } pin_ctrl_t;

    typedef struct packed {
        logic level;
        logic [width_bits-1:0] high_ticks;
        logic [width_bits-1:0] period_ticks;
    } pin_meas_t;
endpackage

// >>> hdl/pin_input_decoder.sv
// One pin: input synchroniser, static level and pulse-width decoder
module pin_input_decoder
    import pin_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_in,
    input wire pin_ctrl_t ctrl,
    output pin_meas_t meas
);
    logic [2:0] sync;
    logic stable;
    logic [10:0] div_cnt;
    logic [10:0] div_limit;
    logic [width_bits-1:0] high_cnt;
    logic [width_bits-1:0] per_cnt;
    logic prev;
    pin_meas_t meas_q;
    logic [2:0] next_sync;
    logic next_stable;
    logic [10:0] next_div_cnt;
    logic [width_bits-1:0] next_high_cnt;
    logic [width_bits-1:0] next_per_cnt;
    logic next_prev;
    pin_meas_t next_meas;
    logic tick;
    logic active;

    // =========================================
    // Synchroniser, divider and measurement
    always_comb
    begin
        next_sync = {sync[1:0], pin_in};
        next_stable = (sync[2] == sync[1]) ? sync[2] : stable;
        active = ctrl.format && !ctrl.direction;
        case (ctrl.timebase)
            tb_code_16: div_limit = tb_periods_16;
            tb_code_64: div_limit = tb_periods_64;
            tb_code_256: div_limit = tb_periods_256;
            tb_code_1024: div_limit = tb_periods_1024;
            default: div_limit = tb_periods_16;
        endcase
        tick = (div_cnt >= div_limit - tb_one);
        next_div_cnt = (!active || tick) ? '0 : div_cnt + tb_one;
        next_high_cnt = high_cnt;
        next_per_cnt = per_cnt;
        next_prev = prev;
        next_meas = meas_q;
        next_meas.level = ctrl.format ? meas_q.level : stable;
        if (!active)
        begin
            next_high_cnt = '0;
            next_per_cnt = '0;
            next_prev = stable;
        end
        else if (tick)
        begin
            next_prev = stable;
            if (stable && !prev)
            begin
                next_meas.period_ticks = per_cnt;
                next_meas.high_ticks = high_cnt;
                next_meas.level = (high_cnt > (per_cnt >> 1));
                next_per_cnt = '0;
                next_high_cnt = '0;
            end
            else
            begin
                if (per_cnt != '1)
                    next_per_cnt = per_cnt + 1'b1;
                if (stable && high_cnt != '1)
                    next_high_cnt = high_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync <= 3'h0;
            stable <= 1'b0;
            div_cnt <= '0;
            high_cnt <= '0;
            per_cnt <= '0;
            prev <= 1'b0;
            meas_q <= '0;
        end
        else
        begin
            sync <= next_sync;
            stable <= next_stable;
            div_cnt <= next_div_cnt;
            high_cnt <= next_high_cnt;
            per_cnt <= next_per_cnt;
            prev <= next_prev;
            meas_q <= next_meas;
        end
    end

    assign meas = meas_q;
endmodule

// >>> verif/dual_pin_gpio_monitor.sv
// Checker of pin drivers and APB answers of the two-pin block
module dual_pin_gpio_monitor
    import pin_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic general_pin_zero_in,
    input wire logic general_pin_zero_out,
    input wire logic general_pin_zero_oe,
    input wire logic general_pin_one_in,
    input wire logic general_pin_one_out,
    input wire logic general_pin_one_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire cfg_wr = psel && penable && pwrite && paddr == cfg_offset;
    wire zero_drive = pwdata[0] & pwdata[8];
    wire one_drive = pwdata[1] & pwdata[9];
    // ========
    // Assertions
    a_dir_zero: assert property (cfg_wr && pstrb[1] |-> ##2 general_pin_zero_oe == $past(pwdata[8], 2))
        else $error("pin zero direction mismatch");
    a_dir_one: assert property (cfg_wr && pstrb[1] |-> ##2 general_pin_one_oe == $past(pwdata[9], 2))
        else $error("pin one direction mismatch");
    a_lvl_zero: assert property (cfg_wr && &pstrb[1:0] |-> ##2 general_pin_zero_out == $past(zero_drive, 2))
        else $error("pin zero level mismatch");
    a_lvl_one: assert property (cfg_wr && &pstrb[1:0] |-> ##2 general_pin_one_out == $past(one_drive, 2))
        else $error("pin one level mismatch");
    a_gate_zero: assert property (general_pin_zero_out |-> general_pin_zero_oe)
        else $error("pin zero driven high while input");
    a_gate_one: assert property (general_pin_one_out |-> general_pin_one_oe)
        else $error("pin one driven high while input");
    a_ro_refused: assert property (psel && penable && pwrite && paddr == level_offset |-> pslverr)
        else $error("status write not refused");
    a_rsv_bit: assert property (psel && penable && !pwrite && paddr == cfg_offset |-> prdata[31:15] == 17'h00001)
        else $error("config upper bits wrong");
    c_cfg_write: cover property (cfg_wr);
    c_refused: cover property (pslverr);
    c_both_high: cover property (general_pin_one_out && general_pin_zero_out);
endmodule

bind dual_pin_gpio dual_pin_gpio_monitor dual_pin_gpio_monitor_i (.*);

// >>> verif/dual_pin_gpio_tb_top.sv
// Bench for the two-pin configuration register and pin drivers
module dual_pin_gpio_tb_top;
    import pin_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, err;
    wire [1:0] oe, out, pin_in;
    logic [1:0] level = 2'h0, pwm_en = 2'h0;
    logic [6:0] high_len = 7'h00;
    int fail_count = 0, checked = 0, cyc = 0;
    initial forever #2 pclk = ~pclk;
    dual_pin_gpio dual_pin_gpio_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .general_pin_zero_in(pin_in[0]), .general_pin_zero_out(out[0]),
        .general_pin_zero_oe(oe[0]), .general_pin_one_in(pin_in[1]),
        .general_pin_one_out(out[1]), .general_pin_one_oe(oe[1]));
    pin_drive_model pin_drive_model_i (.pclk(pclk), .oe(oe), .out(out), .level(level),
        .pwm_en(pwm_en), .high_len(high_len), .pin_in(pin_in));
    // ========
    // Tasks
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            finish_test();
        end
    end
    // ========
    // Tests
    initial
    begin
        logic [1:0] c;
        logic [3:0] v;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, cfg_offset, 32'h0, 4'h0);
        chk(rd, 32'h00008000);
        chk(32'({oe, out}), 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            c = 2'(i);
            apb(1'b1, cfg_offset, {24'h0, c, ~c, c, 2'h0}, 4'h3);
            apb(1'b0, cfg_offset, 32'h0, 4'h0);
            chk(rd, {16'h0, 8'h80, c, ~c, c, 2'h0});
        end
        for (int i = 0; i < 16; i++)
        begin
            v = 4'(i);
            apb(1'b1, cfg_offset, {22'h0, v[3:2], 6'h0, v[1:0]}, 4'h3);
            repeat (2) @(posedge pclk);
            chk(32'({oe, out}), 32'({v[3:2], v[3:2] & v[1:0]}));
        end
        apb(1'b1, cfg_offset, 32'h0, 4'h2);
        apb(1'b0, cfg_offset, 32'h0, 4'h0);
        chk(rd, 32'h00008003);
        chk(32'({oe, out}), 32'h0);
        apb(1'b1, level_offset, 32'hffff, 4'h3);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h008, 32'h0, 4'h0);
        chk({rd[30:0], err}, 32'h1);
        level <= 2'h2;
        repeat (8) @(posedge pclk);
        apb(1'b0, level_offset, 32'h0, 4'h0);
        chk(rd & 32'h3, 32'h2);
        apb(1'b1, cfg_offset, 32'h0c00, 4'h3);
        pwm_en <= 2'h3;
        high_len <= 7'd112;
        repeat (1000) @(posedge pclk);
        apb(1'b0, level_offset, 32'h0, 4'h0);
        chk(rd & 32'h3, 32'h3);
        high_len <= 7'd16;
        repeat (1000) @(posedge pclk);
        apb(1'b0, level_offset, 32'h0, 4'h0);
        chk(rd & 32'h3, 32'h0);
        finish_test();
    end
endmodule

// >>> verif/pin_drive_model.sv
// Far-side circuit on both pins: static level or pulse-width waveform
module pin_drive_model
(
    input wire logic pclk,
    input wire logic [1:0] oe,
    input wire logic [1:0] out,
    input wire logic [1:0] level,
    input wire logic [1:0] pwm_en,
    input wire logic [6:0] high_len,
    output logic [1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] phase = 7'h00;
    wire wave = phase < high_len;
    always @(posedge pclk) phase <= phase + 7'h01;
    // A pin the block drives reads back its own level
    assign pin_in = (oe & out) | (~oe & ((pwm_en & {2{wave}}) | (~pwm_en & level)));
endmodule
